/* File: sp4_pkg.sv */
package sp4_pkg;

  // Deserializer word and divider layout.
  localparam int WORD_BITS = 4;
  localparam int DIV_WIDTH = 3;
  localparam int QUARTER_BIT = 1;
  localparam int EIGHTH_BIT = 2;
  localparam logic [2:0] DIV_CLEAR = 3'h0;
  localparam logic [2:0] DIV_STEP = 3'h1;
  localparam logic [2:0] DIV_LAST_EIGHT = 3'h7;
  localparam logic [1:0] DIV_LAST_FOUR = 2'h3;
  localparam logic [3:0] WORD_CLEAR = 4'h0;

  // Link bundle positions as seen by the synchroniser.
  localparam int SYNC_STAGES = 2;
  localparam int LINK_WIDTH = 5;
  localparam int LINK_CLK = 0;
  localparam int LINK_A = 1;
  localparam int LINK_B = 2;
  localparam int LINK_SLIP = 3;
  localparam int LINK_MR = 4;

  // Host bit clock and pulse lengths, counted in aclk cycles or bit clocks.
  localparam logic [3:0] BIT_HALF_LAST = 4'h1;
  localparam logic [3:0] HOLD_STEP = 4'h1;
  localparam logic [3:0] HOLD_DONE = 4'h1;
  localparam logic [3:0] SLIP_MIN_BIT_CLOCKS = 4'h2;
  localparam logic [3:0] SLIP_HOLD = SLIP_MIN_BIT_CLOCKS + 4'h1;
  localparam logic [3:0] SLIP_GAP = 4'h4;
  localparam logic [3:0] RESET_HOLD = 4'h2;
  localparam logic [4:0] BIT_IDX_STEP = 5'h01;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  // Host register map.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX_WORD = 4'h4;
  localparam logic [3:0] REG_LOOP_WORD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_SLIP_LSB = 8;
  localparam int SLIP_CNT_W = 4;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_COUNT_LSB = 8;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_RESET = 2'b01,
    HOST_SLIP = 2'b11,
    HOST_GAP = 2'b10
  } sp4_host_state_type;

endpackage

/* File: sp4_link_if.sv */
`timescale 1ns/1ps
interface sp4_link_if;
  logic bit_clock;
  logic serial_in_a;
  logic serial_in_b;
  logic bit_slip_pulse;
  logic master_reset;

  modport device (
    input bit_clock,
    input serial_in_a,
    input serial_in_b,
    input bit_slip_pulse,
    input master_reset
  );

  modport host (
    output bit_clock,
    output serial_in_a,
    output serial_in_b,
    output bit_slip_pulse,
    output master_reset
  );
endinterface

/* File: sp4_sync.sv */
`timescale 1ns/1ps
module sp4_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sp4_sync_state_type;

  sp4_sync_state_type state_reg;
  sp4_sync_state_type state_next;

  // The first stage feeds only the second one.
  always_comb begin
    state_next = state_reg;
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;
endmodule

/* File: sp4_device.sv */
`timescale 1ns/1ps
// How it works
// - First received bit lands on output bit zero.
// - Divide bit clock by four and eight.
// - Select high picks input A, low B.
// - Slip pulse lasts at least two bit clocks.
// - Each slip moves start bit down one.
// - One slip pulse per bit position moved.
// - Slip swallows one clock in the dividers.
// - Mode low updates word every four clocks.
// - Mode high updates word every eight clocks.
// - No initial alignment assumed before master reset.
// - Shared master reset aligns all converters.
// - Cascaded pair runs below single-device rate.
// - Receiver captures word with quarter clock.
// - Input A is loopback, B normal line.
module sp4_device (
  input wire logic aclk,
  input wire logic aresetn,
  sp4_link_if.device link,
  input wire logic mode_eight,
  input wire logic select_a,
  output logic [3:0] parallel_out,
  output logic quarter_rate_clock,
  output logic eighth_rate_clock,
  output logic word_strobe,
  output logic slip_done,
  output logic slip_overrun,
  output logic phase_known
);
  typedef struct packed {
    logic bit_clk_d;
    logic slip_d;
    logic [3:0] shift;
    logic [2:0] div;
    logic swallow_pend;
    logic [3:0] parallel;
    logic quarter;
    logic eighth;
    logic word_strobe;
    logic slip_done;
    logic slip_overrun;
    logic phase_known;
  } sp4_device_state_type;

  sp4_device_state_type state_reg;
  sp4_device_state_type state_next;

  logic [sp4_pkg::LINK_WIDTH-1:0] link_raw;
  logic [sp4_pkg::LINK_WIDTH-1:0] link_sync;
  logic bit_clk_s;
  logic slip_s;
  logic reset_s;
  logic serial_bit;
  logic bit_edge;
  logic slip_edge;
  logic boundary;
  logic [3:0] word_in;

  // Every link signal arrives from the other party's timing and is resynced.
  always_comb begin
    link_raw = '0;
    link_raw[sp4_pkg::LINK_CLK] = link.bit_clock;
    link_raw[sp4_pkg::LINK_A] = link.serial_in_a;
    link_raw[sp4_pkg::LINK_B] = link.serial_in_b;
    link_raw[sp4_pkg::LINK_SLIP] = link.bit_slip_pulse;
    link_raw[sp4_pkg::LINK_MR] = link.master_reset;
  end

  sp4_sync #(
    .WIDTH(sp4_pkg::LINK_WIDTH)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(link_raw),
    .sync_out(link_sync)
  );

  assign bit_clk_s = link_sync[sp4_pkg::LINK_CLK];
  assign slip_s = link_sync[sp4_pkg::LINK_SLIP];
  assign reset_s = link_sync[sp4_pkg::LINK_MR];

  // Data and clock share the same synchroniser delay, so the host's
  // mid-bit data change keeps its margin around the sampling edge.
  always_comb begin
    serial_bit = select_a ? link_sync[sp4_pkg::LINK_A] :
                            link_sync[sp4_pkg::LINK_B];
    bit_edge = bit_clk_s & ~state_reg.bit_clk_d;
    slip_edge = slip_s & ~state_reg.slip_d;
    word_in = {serial_bit, state_reg.shift[sp4_pkg::WORD_BITS-1:1]};
    if (mode_eight) begin
      boundary = (state_reg.div == sp4_pkg::DIV_LAST_EIGHT);
    end else begin
      boundary = (state_reg.div[1:0] == sp4_pkg::DIV_LAST_FOUR);
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.bit_clk_d = bit_clk_s;
    state_next.slip_d = slip_s;
    state_next.word_strobe = 1'b0;
    state_next.slip_done = 1'b0;

    if (bit_edge) begin
      state_next.shift = word_in;
      if (state_reg.swallow_pend) begin
        // The divider holds for one bit, so the next word starts one bit
        // later and every earlier bit slides one output lower.
        state_next.swallow_pend = 1'b0;
        state_next.slip_done = 1'b1;
      end else begin
        state_next.div = state_reg.div + sp4_pkg::DIV_STEP;
        if (boundary) begin
          state_next.parallel = word_in;
          state_next.word_strobe = 1'b1;
        end
      end
    end

    // A slip edge taken after the swallow still counts as a new slip.
    if (slip_edge) begin
      if (state_next.swallow_pend) begin
        state_next.slip_overrun = 1'b1;
      end else begin
        state_next.swallow_pend = 1'b1;
      end
    end

    // Held synchronously on aclk, so the link reset acts without any edge
    // of the bit clock; several devices then leave it in the same phase.
    if (reset_s) begin
      state_next.div = sp4_pkg::DIV_CLEAR;
      state_next.shift = sp4_pkg::WORD_CLEAR;
      state_next.parallel = sp4_pkg::WORD_CLEAR;
      state_next.swallow_pend = 1'b0;
      state_next.slip_overrun = 1'b0;
      state_next.word_strobe = 1'b0;
      state_next.slip_done = 1'b0;
      state_next.phase_known = 1'b1;
    end

    state_next.quarter = ~state_next.div[sp4_pkg::QUARTER_BIT];
    state_next.eighth = ~state_next.div[sp4_pkg::EIGHTH_BIT];
  end

  // Without a master reset the divider phase is only a local accident.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.quarter <= 1'b1;
      state_reg.eighth <= 1'b1;
      state_reg.phase_known <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign parallel_out = state_reg.parallel;
  assign quarter_rate_clock = state_reg.quarter;
  assign eighth_rate_clock = state_reg.eighth;
  assign word_strobe = state_reg.word_strobe;
  assign slip_done = state_reg.slip_done;
  assign slip_overrun = state_reg.slip_overrun;
  assign phase_known = state_reg.phase_known;
endmodule

/* File: sp4_host.sv */
`timescale 1ns/1ps
module sp4_host (
  input wire logic aclk,
  input wire logic aresetn,
  sp4_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] tx_word;
    logic [31:0] loop_word;
    logic reset_req;
    logic [3:0] slip_left;
    logic [7:0] slips_sent;
    sp4_pkg::sp4_host_state_type fsm;
    logic [3:0] phase;
    logic [3:0] hold;
    logic [4:0] bit_idx;
    logic bit_clock;
    logic sa;
    logic sb;
    logic slip_out;
    logic mr_out;
  } sp4_host_state_type;

  sp4_host_state_type state_reg;
  sp4_host_state_type state_next;
  logic fall;
  logic busy;

  function automatic logic [31:0] sp4_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    state_next = state_reg;
    fall = 1'b0;
    busy = (state_reg.fsm != sp4_pkg::HOST_IDLE) ||
           (state_reg.slip_left != '0) || state_reg.reset_req;

    // Bit clock divider; data changes on the falling edge only.
    if (state_reg.phase == sp4_pkg::BIT_HALF_LAST) begin
      state_next.phase = '0;
      state_next.bit_clock = ~state_reg.bit_clock;
      fall = state_reg.bit_clock;
    end else begin
      state_next.phase = state_reg.phase + sp4_pkg::HOLD_STEP;
    end

    if (fall) begin
      state_next.sb = state_reg.tx_word[state_reg.bit_idx];
      state_next.sa = state_reg.loop_word[state_reg.bit_idx];
      state_next.bit_idx = state_reg.bit_idx + sp4_pkg::BIT_IDX_STEP;
      state_next.hold = state_reg.hold - sp4_pkg::HOLD_STEP;
      case (state_reg.fsm)
        sp4_pkg::HOST_IDLE: begin
          if (state_reg.reset_req) begin
            state_next.reset_req = 1'b0;
            state_next.mr_out = 1'b1;
            state_next.hold = sp4_pkg::RESET_HOLD;
            state_next.fsm = sp4_pkg::HOST_RESET;
          end else if (state_reg.slip_left != '0) begin
            state_next.slip_out = 1'b1;
            state_next.hold = sp4_pkg::SLIP_HOLD;
            state_next.fsm = sp4_pkg::HOST_SLIP;
          end
        end
        sp4_pkg::HOST_RESET: begin
          if (state_reg.hold == sp4_pkg::HOLD_DONE) begin
            state_next.mr_out = 1'b0;
            state_next.fsm = sp4_pkg::HOST_IDLE;
          end
        end
        sp4_pkg::HOST_SLIP: begin
          if (state_reg.hold == sp4_pkg::HOLD_DONE) begin
            state_next.slip_out = 1'b0;
            state_next.hold = sp4_pkg::SLIP_GAP;
            state_next.slip_left = state_reg.slip_left - 4'h1;
            state_next.slips_sent = state_reg.slips_sent +
                                    sp4_pkg::COUNT_STEP;
            state_next.fsm = sp4_pkg::HOST_GAP;
          end
        end
        sp4_pkg::HOST_GAP: begin
          if (state_reg.hold == sp4_pkg::HOLD_DONE) begin
            state_next.fsm = sp4_pkg::HOST_IDLE;
          end
        end
        default: begin
          state_next.fsm = sp4_pkg::HOST_IDLE;
        end
      endcase
    end

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.waddr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
      state_next.wready = 1'b0;
    end
    if (!state_reg.awready && !state_reg.wready && !state_reg.bvalid) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = sp4_pkg::RESP_OKAY;
      case (state_reg.waddr)
        sp4_pkg::REG_CTRL: begin
          // Requests arriving while busy are dropped; software polls busy.
          if (!busy && state_reg.wstrb[0] &&
              state_reg.wdata[sp4_pkg::CTRL_RESET_BIT]) begin
            state_next.reset_req = 1'b1;
          end
          if (!busy && state_reg.wstrb[1]) begin
            state_next.slip_left = state_reg.wdata[sp4_pkg::CTRL_SLIP_LSB +:
                                                   sp4_pkg::SLIP_CNT_W];
          end
        end
        sp4_pkg::REG_TX_WORD: begin
          state_next.tx_word = sp4_merge(state_reg.tx_word, state_reg.wdata,
                                         state_reg.wstrb);
        end
        sp4_pkg::REG_LOOP_WORD: begin
          state_next.loop_word = sp4_merge(state_reg.loop_word,
                                           state_reg.wdata, state_reg.wstrb);
        end
        sp4_pkg::REG_STATUS: begin
          state_next.bresp = sp4_pkg::RESP_OKAY;
        end
        default: begin
          state_next.bresp = sp4_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end

    // Read channel: one read at a time, answered on the next cycle.
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = sp4_pkg::RESP_OKAY;
      state_next.rdata = sp4_pkg::DATA_RESET;
      case (s_axi_araddr)
        sp4_pkg::REG_CTRL: begin
          state_next.rdata[sp4_pkg::CTRL_SLIP_LSB +: sp4_pkg::SLIP_CNT_W] =
            state_reg.slip_left;
          state_next.rdata[sp4_pkg::CTRL_RESET_BIT] = state_reg.reset_req;
        end
        sp4_pkg::REG_TX_WORD: state_next.rdata = state_reg.tx_word;
        sp4_pkg::REG_LOOP_WORD: state_next.rdata = state_reg.loop_word;
        sp4_pkg::REG_STATUS: begin
          state_next.rdata[sp4_pkg::STATUS_BUSY_BIT] = busy;
          state_next.rdata[sp4_pkg::STATUS_COUNT_LSB +: 8] =
            state_reg.slips_sent;
        end
        default: state_next.rresp = sp4_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.fsm <= sp4_pkg::HOST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign link.bit_clock = state_reg.bit_clock;
  assign link.serial_in_a = state_reg.sa;
  assign link.serial_in_b = state_reg.sb;
  assign link.bit_slip_pulse = state_reg.slip_out;
  assign link.master_reset = state_reg.mr_out;
endmodule

/* File: sp4_monitor.sv */
`timescale 1ns/1ps
module sp4_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_slip_pulse,
  input wire logic master_reset,
  input wire logic mode_eight,
  input wire logic [3:0] parallel_out,
  input wire logic quarter_rate_clock,
  input wire logic eighth_rate_clock,
  input wire logic word_strobe,
  input wire logic slip_done,
  input wire logic slip_overrun,
  input wire logic phase_known
);
  // Word spacing is judged only well away from resets, slips and mode
  // changes, because each of those legally stretches one interval.
  logic [5:0] gap_reg;
  logic [5:0] mr_hist_reg;
  logic [1:0] quiet_reg;
  logic mode_reg;
  logic mr_quiet;
  logic disturb;
  assign mr_quiet = (mr_hist_reg == 6'h00) && !master_reset;
  assign disturb = !mr_quiet || bit_slip_pulse || slip_done ||
    (mode_eight != mode_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 6'h00;
      mr_hist_reg <= 6'h00;
      quiet_reg <= 2'h0;
      mode_reg <= 1'b0;
    end else begin
      mr_hist_reg <= {mr_hist_reg[4:0], master_reset};
      mode_reg <= mode_eight;
      gap_reg <= word_strobe ? 6'h00 :
        (gap_reg == 6'h3F ? gap_reg : gap_reg + 6'h01);
      quiet_reg <= disturb ? 2'h0 :
        ((word_strobe && quiet_reg != 2'h3) ? quiet_reg + 2'h1 : quiet_reg);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_slip_width;
    $rose(bit_slip_pulse) |-> bit_slip_pulse[*8];
  endproperty
  a_slip_width: assert property (p_slip_width)
    else $error("slip pulse shorter than two bit clocks");

  property p_slip_answer;
    $rose(bit_slip_pulse) |-> ##[3:12] slip_done;
  endproperty
  a_slip_answer: assert property (p_slip_answer)
    else $error("slip pulse swallowed no bit clock");

  property p_no_overrun;
    !slip_overrun;
  endproperty
  a_no_overrun: assert property (p_no_overrun)
    else $error("slip pulses overlapped");

  property p_word_gap;
    word_strobe && quiet_reg >= 2'h2 && !disturb |->
      gap_reg == (mode_eight ? 6'h1F : 6'h0F);
  endproperty
  a_word_gap: assert property (p_word_gap)
    else $error("word update spacing wrong");

  property p_strobe_pulse;
    word_strobe |=> !word_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("word strobe longer than one cycle");

  property p_strobe_phase;
    word_strobe && quiet_reg != 2'h0 && !disturb |->
      quarter_rate_clock && (eighth_rate_clock || !mode_eight);
  endproperty
  a_strobe_phase: assert property (p_strobe_phase)
    else $error("word update off the divided clock boundary");

  property p_quarter_high;
    $rose(quarter_rate_clock) && mr_quiet |-> quarter_rate_clock[*8];
  endproperty
  a_quarter_high: assert property (p_quarter_high)
    else $error("quarter clock high phase too short");

  property p_eighth_follows;
    $changed(eighth_rate_clock) && mr_quiet |-> $rose(quarter_rate_clock);
  endproperty
  a_eighth_follows: assert property (p_eighth_follows)
    else $error("eighth clock moved off a quarter clock rise");

  property p_reset_clears;
    $rose(master_reset) |-> ##5 (parallel_out == sp4_pkg::WORD_CLEAR &&
      quarter_rate_clock && eighth_rate_clock && !word_strobe);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("master reset did not clear the dividers");

  property p_phase_known;
    $rose(master_reset) |-> ##[1:8] phase_known;
  endproperty
  a_phase_known: assert property (p_phase_known)
    else $error("phase not marked known after master reset");
endmodule

/* File: sp4_test.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  fail_count++; $display("ERROR at %0t: got %0h expected %0h", $time, \
  (got), (exp)); end end
module sp4_test;
  logic aclk, aresetn, mode_eight, select_a;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] parallel_out;
  logic quarter_rate_clock, eighth_rate_clock, word_strobe;
  logic slip_done, slip_overrun, phase_known;
  int fail_count = 0;
  int n_compared = 0;
  int slip_seen = 0;

  sp4_link_if link ();
  sp4_host i_sp4_host (.aclk, .aresetn, .link(link), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sp4_device i_sp4_device (.aclk, .aresetn, .link(link), .mode_eight,
    .select_a, .parallel_out, .quarter_rate_clock, .eighth_rate_clock,
    .word_strobe, .slip_done, .slip_overrun, .phase_known);
  sp4_monitor i_sp4_monitor (.aclk, .aresetn,
    .bit_slip_pulse(link.bit_slip_pulse), .master_reset(link.master_reset),
    .mode_eight, .parallel_out, .quarter_rate_clock, .eighth_rate_clock,
    .word_strobe, .slip_done, .slip_overrun, .phase_known);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (slip_done === 1'b1) slip_seen++;
  end

  task automatic print_verdict;
    $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timeout;
    fail_count++;
    $display("ERROR at %0t: wait limit used up", $time);
    print_verdict();
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (s_axi_bvalid !== 1'b1) timeout();
    `CHECK(s_axi_bresp, sp4_pkg::RESP_OKAY)
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (s_axi_rvalid !== 1'b1) timeout();
    d = s_axi_rdata;
    `CHECK(s_axi_rresp, sp4_pkg::RESP_OKAY)
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_strobe(output int g);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (word_strobe !== 1'b1 && g < 400);
    if (g >= 400) timeout();
  endtask

  // Early words after a change may straddle old and new data, so skip some.
  task automatic capture(output logic [3:0] w1, w2, output int g);
    repeat (3) wait_strobe(g);
    w1 = parallel_out;
    wait_strobe(g);
    w2 = parallel_out;
    `CHECK(quarter_rate_clock, 1'b1)
  endtask

  function automatic logic [3:0] win(input logic [7:0] p, input int k);
    logic [3:0] r;
    for (int i = 0; i < 4; i++) r[i] = p[(k + i) % 8];
    return r;
  endfunction

  function automatic int find_k(input logic [7:0] p, input logic [3:0] a,
                                input logic [3:0] b);
    for (int k = 0; k < 8; k++) begin
      if (win(p, k) === a && win(p, (k + 4) % 8) === b) return k;
    end
    return -1;
  endfunction

  initial begin
    logic [31:0] d;
    logic [3:0] w1, w2;
    logic [7:0] c0;
    int g, k, k2, n, s0;
    aresetn = 1'b0;
    mode_eight = 1'b0;
    select_a = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_write(sp4_pkg::REG_STATUS, 32'hFFFF_FFFF, 4'hF);
    for (int i = 0; i < 4; i++) begin
      axi_read(4'(4 * i), d);
      `CHECK(d, sp4_pkg::DATA_RESET)
    end
    $display("Test registers done");
    axi_write(sp4_pkg::REG_TX_WORD, 32'h1D1D_1D1D, 4'hF);
    axi_write(sp4_pkg::REG_LOOP_WORD, 32'hE2E2_E2E2, 4'hF);
    axi_write(sp4_pkg::REG_TX_WORD, 32'h0000_0000, 4'h0);
    axi_read(sp4_pkg::REG_TX_WORD, d);
    `CHECK(d, 32'h1D1D_1D1D)
    `CHECK(phase_known, 1'b0)
    axi_write(sp4_pkg::REG_CTRL, 32'h0000_0001, 4'h1);
    n = 0;
    while (phase_known !== 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 400) timeout();
    `CHECK(phase_known, 1'b1)
    capture(w1, w2, g);
    k = find_k(8'h1D, w1, w2);
    `CHECK(k >= 0, 1'b1)
    `CHECK(g, 16)
    $display("Test four bit words done");
    select_a <= 1'b1;
    capture(w1, w2, g);
    `CHECK(find_k(8'hE2, w1, w2) >= 0, 1'b1)
    select_a <= 1'b0;
    capture(w1, w2, g);
    k = find_k(8'h1D, w1, w2);
    `CHECK(k >= 0, 1'b1)
    $display("Test input select done");
    for (int j = 1; j <= 3; j += 2) begin
      axi_read(sp4_pkg::REG_STATUS, d);
      c0 = d[15:8];
      s0 = slip_seen;
      axi_write(sp4_pkg::REG_CTRL, 32'(j) << 8, 4'h2);
      axi_read(sp4_pkg::REG_STATUS, d);
      `CHECK(d[0], 1'b1)
      n = 0;
      while (d[0] !== 1'b0 && n < 50) begin
        axi_read(sp4_pkg::REG_STATUS, d);
        n++;
      end
      if (n >= 50) timeout();
      `CHECK(d[15:8], c0 + 8'(j))
      `CHECK(slip_seen - s0, j)
      capture(w1, w2, g);
      k2 = find_k(8'h1D, w1, w2);
      `CHECK(k2 >= 0 && ((k2 - k - j) & 3) == 0, 1'b1)
      k = k2;
    end
    `CHECK(slip_overrun, 1'b0)
    $display("Test bit slip done");
    mode_eight <= 1'b1;
    capture(w1, w2, g);
    `CHECK(g, 32)
    `CHECK(eighth_rate_clock, 1'b1)
    `CHECK(w1, w2)
    mode_eight <= 1'b0;
    $display("Test eight bit mode done");
    axi_write(sp4_pkg::REG_CTRL, 32'h0000_0001, 4'h1);
    capture(w1, w2, g);
    `CHECK(find_k(8'h1D, w1, w2) >= 0, 1'b1)
    `CHECK(g, 16)
    $display("Test second master reset done");
    print_verdict();
  end
endmodule
